//--- src/adc_seq_pkg.sv
// Constants, modes and states of the delta-sigma conversion sequencer.
// Assumes one 20 MHz system clock shared by every user of the package.
package adc_seq_pkg;

   // =========================================================
   // Widths
   localparam int DATA_W = 20;
   localparam int PER_W = 16;
   localparam int FIFO_DEPTH = 8;

   // =========================================================
   // Conversion modes
   localparam logic [1:0] MODE_SINGLE = 2'h0;
   localparam logic [1:0] MODE_CONT = 2'h1;
   localparam logic [1:0] MODE_MULTI = 2'h2;
   localparam logic [1:0] MODE_TURBO = 2'h3;

   // =========================================================
   // Decimator priming and resolution limits
   localparam logic [1:0] PRIME_CONV = 2'h3;
   localparam logic [4:0] RES_TURBO_MAX = 5'h10;

   // =========================================================
   // Timing
   localparam int CLK_NS = 50;
   localparam int MOD_RST_NS = 100;
   localparam int MOD_RST_CYC_I = (MOD_RST_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] MOD_RST_CYC = 4'(MOD_RST_CYC_I);
   localparam logic [PER_W-1:0] CONV_PERIOD_RST = 16'h0001;

   // =========================================================
   // Sequencer states
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_RESET = 4'h2,
      ST_CONV = 4'h4,
      ST_HOLD = 4'h8
   } seq_state_e;

endpackage

//--- src/conv_timer.sv
// Conversion period divider: one tick per finished conversion.
// Assumes period comes from static configuration on the same clock.
`timescale 1ns/1ps
`default_nettype none

module conv_timer (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Control
   input wire logic en_i,
   input wire logic clr_i,
   input wire logic [adc_seq_pkg::PER_W-1:0] period_i,
   // Tick
   output logic tick_o
);

   logic [adc_seq_pkg::PER_W-1:0] cnt_r, cnt_nxt, last;
   logic tick_r, tick_nxt;

   // =========================================================
   // Divider
   always_comb
   begin
      // Zero period behaves as one cycle
      last = (period_i == '0) ? '0 : period_i - 1'b1;
      cnt_nxt = cnt_r;
      tick_nxt = 1'b0;
      if (clr_i)
      begin
         cnt_nxt = '0;
      end
      else if (en_i)
      begin
         if (cnt_r >= last)
         begin
            cnt_nxt = '0;
            tick_nxt = 1'b1;
         end
         else
         begin
            cnt_nxt = cnt_r + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         cnt_r <= '0;
         tick_r <= 1'b0;
      end
      else
      begin
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick_o = tick_r;

endmodule

`default_nettype wire

//--- src/delta_sigma_adc_sequencer.sv
// Conversion sequencer for a delta-sigma converter's decimator.
// Assumes decimator data is stable on the clock; start pin is async.
// Operation
// - Single mode waits in standby until a start trigger arrives.
// - Single mode runs four conversions; first three only prime.
// - Single result valid after fourth conversion; done raised then.
// - After single result leaves, return to standby for next start.
// - Continuous mode's first result follows three priming conversions.
// - Continuous mode then yields one result per period, no triggers.
// - Multi mode resets converter and reprimes before every sample.
// - Multi mode starts the next sample automatically.
// - Turbo mode equals multi mode for resolutions 8 to 16 bits.
// - Turbo at 17 to 20 bits resets only once, at the end; the code also resets at the start, as every mode does.
// - Continuous mode works with the start pin left unconnected.
// - Done goes high at the end of every conversion that yields a result, not after priming ones.
// - Done and status stay high until the result is read.
// - Any mode starts on software start bit or start pin.
// - After mux switch, data invalid until fourth sample completes.
`timescale 1ns/1ps
`default_nettype none

module delta_sigma_adc_sequencer (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Configuration
   input wire logic [1:0] mode_i,
   input wire logic [4:0] res_bits_i,
   input wire logic [adc_seq_pkg::PER_W-1:0] conv_period_i,
   // Control
   input wire logic sw_start_i,
   input wire logic stop_i,
   input wire logic start_conv_i,
   input wire logic mux_switch_i,
   input wire logic clr_overrun_i,
   // Decimator
   input wire logic [adc_seq_pkg::DATA_W-1:0] dec_data_i,
   output logic mod_reset_o,
   // Result side
   output logic [adc_seq_pkg::DATA_W-1:0] result_o,
   output logic result_valid_o,
   input wire logic rd_ready_i,
   output logic conversion_done_o,
   output logic done_status_o,
   // Status
   output logic conv_active_o,
   output logic overrun_o
);

   adc_seq_pkg::seq_state_e state_r, state_nxt, after;
   logic [1:0] mode_r, mode_nxt, prime_r, prime_nxt;
   logic [3:0] rcnt_r, rcnt_nxt;
   logic turbo_r, turbo_nxt, end_r, end_nxt;
   logic [adc_seq_pkg::DATA_W-1:0] hold_r, hold_nxt, push_data;
   logic ovr_r, ovr_nxt, mrst_r, mrst_nxt, act_r, act_nxt;
   logic sync1_r, sync2_r, sync3_r;
   logic start_evt, push, stream, tick, timer_clr, fifo_rdy, fifo_vld;

   // =========================================================
   // Start pin synchroniser
   // idle pin starts nothing, so it may stay unconnected
   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         sync1_r <= 1'b0;
         sync2_r <= 1'b0;
         sync3_r <= 1'b0;
      end
      else
      begin
         sync1_r <= start_conv_i;
         sync2_r <= sync1_r;
         sync3_r <= sync2_r;
      end
   end

   assign start_evt = sw_start_i | (sync2_r & ~sync3_r);

   // =========================================================
   // Conversion period
   conv_timer u_timer (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .en_i(state_r == adc_seq_pkg::ST_CONV),
      .clr_i(timer_clr),
      .period_i(conv_period_i),
      .tick_o(tick)
   );

   // =========================================================
   // Sequencer
   always_comb
   begin
      state_nxt = state_r;
      mode_nxt = mode_r;
      prime_nxt = prime_r;
      rcnt_nxt = rcnt_r;
      turbo_nxt = turbo_r;
      end_nxt = end_r;
      hold_nxt = hold_r;
      push = 1'b0;
      push_data = dec_data_i;
      timer_clr = 1'b0;
      // Clear first, so a set in the same cycle wins
      ovr_nxt = ovr_r & ~clr_overrun_i;
      stream = (mode_r == adc_seq_pkg::MODE_CONT) ||
               ((mode_r == adc_seq_pkg::MODE_TURBO) && turbo_r);
      if (mode_r == adc_seq_pkg::MODE_SINGLE)
      begin
         after = adc_seq_pkg::ST_IDLE;
      end
      else if (stream)
      begin
         after = adc_seq_pkg::ST_CONV;
      end
      else
      begin
         after = adc_seq_pkg::ST_RESET;
      end
      case (state_r)
         adc_seq_pkg::ST_IDLE:
         begin
            if (start_evt)
            begin
               mode_nxt = mode_i;
               // only above 16 bits turbo differs
               turbo_nxt = (res_bits_i > adc_seq_pkg::RES_TURBO_MAX);
               end_nxt = 1'b0;
               rcnt_nxt = '0;
               state_nxt = adc_seq_pkg::ST_RESET;
            end
         end
         adc_seq_pkg::ST_RESET:
         begin
            if (rcnt_r == adc_seq_pkg::MOD_RST_CYC - 4'h1)
            begin
               rcnt_nxt = '0;
               prime_nxt = '0;
               timer_clr = 1'b1;
               state_nxt = end_r ? adc_seq_pkg::ST_IDLE :
                           adc_seq_pkg::ST_CONV;
            end
            else
            begin
               rcnt_nxt = rcnt_r + 4'h1;
            end
         end
         adc_seq_pkg::ST_CONV:
         begin
            if (stop_i)
            begin
               // high-res turbo resets once, at the end
               end_nxt = (mode_r == adc_seq_pkg::MODE_TURBO) & turbo_r;
               state_nxt = end_nxt ? adc_seq_pkg::ST_RESET :
                           adc_seq_pkg::ST_IDLE;
            end
            else if (mux_switch_i)
            begin
               prime_nxt = '0;
               timer_clr = 1'b1;
            end
            else if (tick)
            begin
               if (prime_r != adc_seq_pkg::PRIME_CONV)
               begin
                  prime_nxt = prime_r + 2'h1;
               end
               else if (fifo_rdy)
               begin
                  push = 1'b1;
                  state_nxt = after;
               end
               // Streaming cannot wait; losing a word is flagged
               else if (stream)
               begin
                  ovr_nxt = 1'b1;
               end
               else
               begin
                  hold_nxt = dec_data_i;
                  state_nxt = adc_seq_pkg::ST_HOLD;
               end
            end
         end
         adc_seq_pkg::ST_HOLD:
         begin
            if (stop_i)
            begin
               state_nxt = adc_seq_pkg::ST_IDLE;
            end
            else if (fifo_rdy)
            begin
               push = 1'b1;
               push_data = hold_r;
               state_nxt = after;
            end
         end
         default:
         begin
            state_nxt = adc_seq_pkg::ST_IDLE;
         end
      endcase
      mrst_nxt = (state_nxt == adc_seq_pkg::ST_RESET);
      act_nxt = (state_nxt != adc_seq_pkg::ST_IDLE);
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         state_r <= adc_seq_pkg::ST_IDLE;
         mode_r <= adc_seq_pkg::MODE_SINGLE;
         prime_r <= '0;
         rcnt_r <= '0;
         turbo_r <= 1'b0;
         end_r <= 1'b0;
         hold_r <= '0;
         ovr_r <= 1'b0;
         mrst_r <= 1'b0;
         act_r <= 1'b0;
      end
      else
      begin
         state_r <= state_nxt;
         mode_r <= mode_nxt;
         prime_r <= prime_nxt;
         rcnt_r <= rcnt_nxt;
         turbo_r <= turbo_nxt;
         end_r <= end_nxt;
         hold_r <= hold_nxt;
         ovr_r <= ovr_nxt;
         mrst_r <= mrst_nxt;
         act_r <= act_nxt;
      end
   end

   // =========================================================
   // Result buffer
   result_fifo #(
      .W(adc_seq_pkg::DATA_W),
      .DEPTH(adc_seq_pkg::FIFO_DEPTH)
   ) u_fifo (
      .mclk_i(mclk_i),
      .rst_i(rst_i),
      .in_valid_i(push),
      .in_ready_o(fifo_rdy),
      .in_data_i(push_data),
      .out_valid_o(fifo_vld),
      .out_ready_i(rd_ready_i),
      .out_data_o(result_o)
   );

   assign conversion_done_o = fifo_vld;
   assign done_status_o = fifo_vld;
   assign result_valid_o = fifo_vld;
   assign mod_reset_o = mrst_r;
   assign conv_active_o = act_r;
   assign overrun_o = ovr_r;

   // =========================================================
   // Checks
   chk_idle_wait: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_r == adc_seq_pkg::ST_IDLE) && !start_evt
      |=> (state_r == adc_seq_pkg::ST_IDLE) && !conv_active_o)
      else $error("left standby without start");
   chk_prime_count: assert property (@(posedge mclk_i) disable iff (rst_i)
      push && (state_r == adc_seq_pkg::ST_CONV)
      |-> prime_r == adc_seq_pkg::PRIME_CONV && tick)
      else $error("result before priming done");
   chk_single_back: assert property (@(posedge mclk_i) disable iff (rst_i)
      push && (mode_r == adc_seq_pkg::MODE_SINGLE)
      |=> (state_r == adc_seq_pkg::ST_IDLE) && conversion_done_o)
      else $error("single mode did not return to standby");
   chk_multi_reset: assert property (@(posedge mclk_i) disable iff (rst_i)
      push && (mode_r == adc_seq_pkg::MODE_MULTI)
      |=> mod_reset_o ##2 (state_r == adc_seq_pkg::ST_CONV))
      else $error("multi mode did not reprime");
   chk_turbo_once: assert property (@(posedge mclk_i) disable iff (rst_i)
      push && (mode_r == adc_seq_pkg::MODE_TURBO) && turbo_r
      |=> !mod_reset_o && (state_r == adc_seq_pkg::ST_CONV))
      else $error("high-res turbo reset between samples");
   chk_cont_runs: assert property (@(posedge mclk_i) disable iff (rst_i)
      push && (mode_r == adc_seq_pkg::MODE_CONT)
      |=> (state_r == adc_seq_pkg::ST_CONV) &&
          (prime_r == adc_seq_pkg::PRIME_CONV))
      else $error("continuous mode stopped streaming");
   chk_done_after: assert property (@(posedge mclk_i) disable iff (rst_i)
      push |=> conversion_done_o && done_status_o)
      else $error("done not raised after conversion");
   chk_done_holds: assert property (@(posedge mclk_i) disable iff (rst_i)
      conversion_done_o && !rd_ready_i |=> conversion_done_o)
      else $error("done dropped before read");
   chk_mode_latch: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_r == adc_seq_pkg::ST_IDLE) && start_evt
      |=> mode_r == $past(mode_i) && conv_active_o)
      else $error("mode not sampled at start");
   chk_mux_reprime: assert property (@(posedge mclk_i) disable iff (rst_i)
      (state_r == adc_seq_pkg::ST_CONV) && mux_switch_i && !stop_i
      |=> (prime_r == 2'h0) && !push)
      else $error("mux switch did not restart priming");

endmodule

`default_nettype wire

//--- src/result_fifo.sv
// Result FIFO between the sequencer and the reading party.
// Assumes push and pop come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module result_fifo #(
   parameter int W = 20,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Filling side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [W-1:0] in_data_i,
   // Draining side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] DEPTH_C = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

   logic [W-1:0] mem_r [DEPTH];
   logic [AW-1:0] wr_r, wr_nxt, rd_r, rd_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic full_r, full_nxt, vld_r, vld_nxt;
   logic push, pop;

   // =========================================================
   // Pointer and level update
   always_comb
   begin
      push = in_valid_i & ~full_r;
      pop = out_ready_i & vld_r;
      wr_nxt = push ? ((wr_r == LAST_C) ? '0 : wr_r + 1'b1) : wr_r;
      rd_nxt = pop ? ((rd_r == LAST_C) ? '0 : rd_r + 1'b1) : rd_r;
      cnt_nxt = cnt_r;
      if (push && !pop)
      begin
         cnt_nxt = cnt_r + 1'b1;
      end
      else if (pop && !push)
      begin
         cnt_nxt = cnt_r - 1'b1;
      end
      full_nxt = (cnt_nxt == DEPTH_C);
      vld_nxt = (cnt_nxt != '0);
   end

   always_ff @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         wr_r <= '0;
         rd_r <= '0;
         cnt_r <= '0;
         full_r <= 1'b0;
         vld_r <= 1'b0;
      end
      else
      begin
         wr_r <= wr_nxt;
         rd_r <= rd_nxt;
         cnt_r <= cnt_nxt;
         full_r <= full_nxt;
         vld_r <= vld_nxt;
      end
   end

   // Storage has no reset; valid flag masks stale words
   always_ff @(posedge mclk_i)
   begin
      if (push)
      begin
         mem_r[wr_r] <= in_data_i;
      end
   end

   assign in_ready_o = ~full_r;
   assign out_valid_o = vld_r;
   assign out_data_o = mem_r[rd_r];

endmodule

`default_nettype wire

//--- tb/result_reader.sv
// Reader model: a CPU or DMA engine draining conversion results.
// Assumes results and flags come from the sequencer on the same clock.
`timescale 1ns/1ps
`default_nettype none

module result_reader (
   // Clock and reset
   input wire logic mclk_i,
   input wire logic rst_i,
   // Sequencer result side
   input wire logic [adc_seq_pkg::DATA_W-1:0] result_i,
   input wire logic valid_i,
   input wire logic done_i,
   output logic rd_ready_o,
   // Bench control and view
   input wire logic stall_i,
   output logic [7:0] taken_o,
   output logic [adc_seq_pkg::DATA_W-1:0] last_o
);
   // ==========================================================
   // Read request
   // done used as request, stall holds it low
   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
         rd_ready_o <= 1'b0;
      else
         rd_ready_o <= #2 done_i & ~stall_i;
   end

   // ==========================================================
   // Capture
   // Reacts one cycle late, like a real request path would
   always @(posedge mclk_i or posedge rst_i)
   begin
      if (rst_i)
      begin
         taken_o <= 8'h00;
         last_o <= '0;
      end
      else if (valid_i && rd_ready_o)
      begin
         taken_o <= taken_o + 8'h01;
         last_o <= result_i;
      end
   end
endmodule
`default_nettype wire

//--- tb/tb_delta_sigma_adc_sequencer.sv
// Self-checking bench for the conversion sequencer.
// Assumes the package, design files and reader model compile first.
`timescale 1ns/1ps
`default_nettype none

module tb_delta_sigma_adc_sequencer;
   localparam int P = 4;
   localparam int LAT = 3 + 4 * P;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] mode = 2'h0;
   logic [4:0] res = 5'h10;
   logic [15:0] period = 16'h0004;
   logic sw_start = 1'b0;
   logic stop = 1'b0;
   logic start_pin = 1'b0;
   logic mux_sw = 1'b0;
   logic clr_ovr = 1'b0;
   logic [19:0] dec_data = 20'h5a5a5;
   logic mod_reset, rvalid, rd_ready, done, done_st, active, overrun;
   logic stall = 1'b0;
   logic [19:0] result, last;
   logic [7:0] taken, base;
   int error_cnt = 0;
   int n_tests = 0;
   int cyc = 0;
   int n;
   int t_res [5] = '{12, 8, 16, 17, 20};

   always #25 mclk = ~mclk;

   delta_sigma_adc_sequencer u_dut (.mclk_i(mclk), .rst_i(rst),
      .mode_i(mode), .res_bits_i(res), .conv_period_i(period),
      .sw_start_i(sw_start), .stop_i(stop), .start_conv_i(start_pin),
      .mux_switch_i(mux_sw), .clr_overrun_i(clr_ovr),
      .dec_data_i(dec_data), .mod_reset_o(mod_reset), .result_o(result),
      .result_valid_o(rvalid), .rd_ready_i(rd_ready),
      .conversion_done_o(done), .done_status_o(done_st),
      .conv_active_o(active), .overrun_o(overrun));

   result_reader u_reader (.mclk_i(mclk), .rst_i(rst), .result_i(result),
      .valid_i(rvalid), .done_i(done), .rd_ready_o(rd_ready),
      .stall_i(stall), .taken_o(taken), .last_o(last));

   // ==========================================================
   // Helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                        input string what);
      n_tests++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected at %0t: %s seen %0h expected %0h",
                  $time, what, seen, exp);
      end
   endtask

   task automatic step(input int k);
      repeat (k) @(posedge mclk);
      #2;
   endtask

   task automatic kick();
      sw_start = 1'b1;
      step(1);
      sw_start = 1'b0;
   endtask

   // Held three edges: a stop seen during modulator reset is ignored
   task automatic halt();
      stop = 1'b1;
      step(3);
      stop = 1'b0;
      step(6);
   endtask

   // Bounded waits; a hang shows up as a wrong count
   task automatic wait_valid(output int cnt);
      cnt = 0;
      while (rvalid !== 1'b1 && cnt < 2000)
      begin
         step(1);
         cnt++;
      end
   endtask

   task automatic next_result(output int cnt);
      int m;
      cnt = 0;
      while (rvalid === 1'b1 && cnt < 2000)
      begin
         step(1);
         cnt++;
      end
      wait_valid(m);
      cnt = cnt + m;
   endtask

   task automatic wrap_up();
      $display("checks %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cyc++;
      if (cyc == 30000)
      begin
         error_cnt++;
         wrap_up();
      end
   end

   // ==========================================================
   // Tests
   initial
   begin
      step(6);
      rst = 1'b0;
      step(1);
      check({active, rvalid, mod_reset, overrun}, 4'h0, "reset flags");
      $display("test reset done");

      // Single sample, reader stalled
      stall = 1'b1;
      kick();
      mode = adc_seq_pkg::MODE_CONT;
      check(mod_reset, 1'b1, "mod reset first");
      step(1);
      check(mod_reset, 1'b1, "mod reset second");
      step(1);
      check(mod_reset, 1'b0, "mod reset end");
      wait_valid(n);
      check(n + 2, LAT, "single latency");
      check({done, done_st}, 2'h3, "done raised");
      step(10);
      check({done, done_st}, 2'h3, "done held");
      stall = 1'b0;
      step(4);
      check({done, last, taken}, {1'b0, 20'h5a5a5, 8'h01}, "single read");
      check(active, 1'b0, "single back idle");
      step(3 * LAT);
      check({rvalid, taken}, {1'b0, 8'h01}, "standby");
      $display("test single done");

      // Start pin, driven high once and held until the result
      mode = adc_seq_pkg::MODE_SINGLE;
      dec_data = 20'h0c3a1;
      start_pin = 1'b1;
      wait_valid(n);
      check(n >= LAT && n <= LAT + 3, 1'b1, "pin latency");
      start_pin = 1'b0;
      step(4);
      check({last, taken}, {20'h0c3a1, 8'h02}, "pin result");
      $display("test start pin done");

      // Continuous, start pin left low
      mode = adc_seq_pkg::MODE_CONT;
      kick();
      wait_valid(n);
      check(n, LAT, "prime latency");
      repeat (3)
      begin
         next_result(n);
         check(n, P, "stream period");
      end
      halt();
      check(active, 1'b0, "stop cont");
      $display("test continuous done");

      // Multi at 12 bits, then turbo at each resolution band
      for (int i = 0; i < 5; i++)
      begin
         mode = (i == 0) ? adc_seq_pkg::MODE_MULTI : adc_seq_pkg::MODE_TURBO;
         res = 5'(t_res[i]);
         kick();
         wait_valid(n);
         next_result(n);
         // Gap tells whether a reset came between samples
         check(n, (t_res[i] > 16) ? P : LAT,
               "sample gap");
         if (i == 4)
         begin
            // mux moved only outside continuous mode
            mux_sw = 1'b1;
            step(1);
            mux_sw = 1'b0;
            next_result(n);
            check(n + 1 >= 4 * P && n + 1 <= 4 * P + 2, 1'b1, "reprime");
         end
         halt();
         check(active, 1'b0, "stop multi");
      end
      $display("test multi done");

      // Fill until refused: streaming drops a word, multi holds it
      for (int j = 0; j < 2; j++)
      begin
         mode = (j == 0) ? adc_seq_pkg::MODE_CONT : adc_seq_pkg::MODE_MULTI;
         stall = 1'b1;
         base = taken;
         kick();
         step((j == 0) ? LAT + 10 * P : 9 * LAT + 5);
         check({rvalid, overrun, active}, {1'b1, j == 0, 1'b1},
               "full");
         halt();
         clr_ovr = 1'b1;
         step(1);
         clr_ovr = 1'b0;
         step(1);
         check(overrun, 1'b0, "overrun clear");
         stall = 1'b0;
         step(30);
         check(taken - base, 8'(adc_seq_pkg::FIFO_DEPTH),
               "drain count");
         check(rvalid, 1'b0, "drained");
      end
      $display("test fifo done");
      wrap_up();
   end
endmodule
`default_nettype wire
